// File: rtl/ctm_timer.sv
`timescale 1ns/100ps
`default_nettype none

module ctm_timer
   import ctm_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             pin_out,
   output logic             pin_oe,
   output logic             match_a_flag,
   output logic             match_p_flag
);

   // All state of the block lives in one record.
   typedef struct packed {
      logic [CNT_W-1:0] count;
      logic             timer_on;
      mode_type         mode;
      logic [1:0]       pin_func;
      logic             init_level;
      logic             pol_inv;
      logic             swap;
      logic             clr_sel;
      logic [CNT_W-1:0] cmp_a;
      logic [P_W-1:0]   cmp_p;
      logic             flag_a;
      logic             flag_p;
      logic             pin;
      logic             pin_en;
      logic             ack;
      logic [31:0]      rdata;
   } state_type;

   localparam state_type STATE_RESET = '{
      count:      10'h000,
      timer_on:   1'b0,
      mode:       MODE_COMPARE,
      pin_func:   2'h0,
      init_level: 1'b0,
      pol_inv:    1'b0,
      swap:       1'b0,
      clr_sel:    1'b0,
      cmp_a:      CMP_A_RESET,
      cmp_p:      CMP_P_RESET,
      flag_a:     1'b0,
      flag_p:     1'b0,
      pin:        1'b0,
      pin_en:     1'b0,
      ack:        1'b0,
      rdata:      32'h0000_0000
   };

   state_type state_reg;
   state_type state_next;

   logic a_hit;
   logic p_hit;
   logic pwm_active;

   // Comparators watch the running count.
   ctm_compare u_compare (
      .count (state_reg.count),
      .cmp_a (state_reg.cmp_a),
      .cmp_p (state_reg.cmp_p),
      .a_hit (a_hit),
      .p_hit (p_hit)
   );

   // Duty and period are resolved from the compare values.
   ctm_pwm_level u_pwm_level (
      .count  (state_reg.count),
      .cmp_a  (state_reg.cmp_a),
      .cmp_p  (state_reg.cmp_p),
      .swap   (state_reg.swap),
      .active (pwm_active)
   );

   // Bus request decode.
   logic       req;
   logic       wr;
   logic       lane0;
   logic       lane1;
   logic       hit_ctrl;
   logic       hit_config;
   logic       hit_cmp_a;
   logic       hit_cmp_p;
   logic       hit_status;
   logic [7:0] config_view;
   logic [31:0] read_mux;

   // A request is served once; ack drops the cycle after it rises.
   assign req   = wb_cyc_i && wb_stb_i && !state_reg.ack;
   // A write lands at the edge where the master samples ack, while it still holds the request.
   assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && state_reg.ack;
   assign lane0 = wb_sel_i[0];
   assign lane1 = wb_sel_i[1];

   assign hit_ctrl   = (wb_adr_i == ADDR_CTRL);
   assign hit_config = (wb_adr_i == ADDR_CONFIG);
   assign hit_cmp_a  = (wb_adr_i == ADDR_CMP_A);
   assign hit_cmp_p  = (wb_adr_i == ADDR_CMP_P);
   assign hit_status = (wb_adr_i == ADDR_STATUS);

   // Configuration byte in the same bit order as it is written.
   assign config_view = {state_reg.mode,
                         state_reg.pin_func,
                         state_reg.init_level,
                         state_reg.pol_inv,
                         state_reg.swap,
                         state_reg.clr_sel};

   // Read data; unmapped offsets answer with zero.
   always_comb begin
      read_mux = 32'h0000_0000;
      case (wb_adr_i)
         ADDR_CTRL: begin
            read_mux[CTRL_ON_BIT] = state_reg.timer_on;
         end
         ADDR_CONFIG: begin
            read_mux[7:0] = config_view;
         end
         ADDR_CMP_A: begin
            read_mux[CNT_W-1:0] = state_reg.cmp_a;
         end
         ADDR_CMP_P: begin
            read_mux[P_W-1:0] = state_reg.cmp_p;
         end
         ADDR_COUNT: begin
            read_mux[CNT_W-1:0] = state_reg.count;
         end
         ADDR_STATUS: begin
            read_mux[STAT_A_BIT]   = state_reg.flag_a;
            read_mux[STAT_P_BIT]   = state_reg.flag_p;
            read_mux[STAT_PIN_BIT] = state_reg.pin;
         end
         default: begin
            read_mux = 32'h0000_0000;
         end
      endcase
   end

   // Counter events for the present mode.
   logic on_rise;
   logic running;
   logic pwm_mode;
   logic cmp_mode;
   logic clear_now;
   logic set_a;
   logic set_p;
   logic clr_a;
   logic clr_p;
   logic level;

   assign running  = state_reg.timer_on;
   assign pwm_mode = (state_reg.mode == MODE_PWM);
   assign cmp_mode = (state_reg.mode == MODE_COMPARE);

   // Only a write that turns the timer on from off counts as the rising edge.
   assign on_rise = wr && hit_ctrl && lane0 && wb_dat_i[CTRL_ON_BIT]
                    && !state_reg.timer_on;

   // Flag clears from software, write one to clear.
   assign clr_a = wr && hit_status && lane0 && wb_dat_i[STAT_A_BIT];
   assign clr_p = wr && hit_status && lane0 && wb_dat_i[STAT_P_BIT];

   // Clear source and flag sources per mode.
   always_comb begin
      clear_now = 1'b0;
      set_a     = 1'b0;
      set_p     = 1'b0;
      if (running) begin
         if (pwm_mode) begin
            clear_now = state_reg.swap ? a_hit : p_hit;
            set_a = a_hit;
            set_p = p_hit;
         end else if (state_reg.clr_sel) begin
            clear_now = a_hit;
            set_a = a_hit;
            set_p = 1'b0;
         end else begin
            clear_now = p_hit;
            set_a = a_hit;
            set_p = p_hit;
         end
      end
   end

   // PWM pin level before the final inversion.
   always_comb begin
      case (state_reg.pin_func)
         FUNC_FORCE_OFF: begin
            level = !state_reg.init_level;
         end
         FUNC_FORCE_ON: begin
            level = state_reg.init_level;
         end
         default: begin
            level = pwm_active ? state_reg.init_level
                               : !state_reg.init_level;
         end
      endcase
   end

   // Next state of the whole block.
   always_comb begin
      state_next = state_reg;

      // Bus answer: one registered cycle after the request is seen.
      state_next.ack   = req;
      state_next.rdata = req ? read_mux : 32'h0000_0000;

      // Register writes take effect at the edge that sees ack high.
      if (wr && hit_ctrl && lane0) begin
         state_next.timer_on = wb_dat_i[CTRL_ON_BIT];
      end
      if (wr && hit_config && lane0) begin
         state_next.mode       = mode_type'(wb_dat_i[CFG_MODE_LSB +: 2]);
         state_next.pin_func   = wb_dat_i[CFG_FUNC_LSB +: 2];
         state_next.init_level = wb_dat_i[CFG_INIT_BIT];
         state_next.pol_inv    = wb_dat_i[CFG_POL_BIT];
         state_next.swap       = wb_dat_i[CFG_SWAP_BIT];
         state_next.clr_sel    = wb_dat_i[CFG_CLR_SEL_BIT];
      end
      if (wr && hit_cmp_a) begin
         if (lane0) begin
            state_next.cmp_a[7:0] = wb_dat_i[7:0];
         end
         if (lane1) begin
            state_next.cmp_a[CNT_W-1:8] = wb_dat_i[CNT_W-1:8];
         end
      end
      if (wr && hit_cmp_p && lane0) begin
         state_next.cmp_p = wb_dat_i[P_W-1:0];
      end

      // Counting; a stopped timer keeps its residual count.
      if (on_rise) begin
         state_next.count = 10'h000;
      end else if (running) begin
         if (clear_now) begin
            state_next.count = 10'h000;
         end else begin
            // Wraps at 3FF when no clear source fires.
            state_next.count = state_reg.count + 10'h001;
         end
      end

      // Hardware set beats a software clear in the same cycle.
      state_next.flag_a = (state_reg.flag_a && !clr_a) || set_a;
      state_next.flag_p = (state_reg.flag_p && !clr_p) || set_p;

      // Pin driver: enabled in compare and PWM modes only.
      // pin left free
      state_next.pin_en = cmp_mode || pwm_mode;

      if (on_rise) begin
         state_next.pin = state_reg.init_level;
      end else if (pwm_mode) begin
         state_next.pin = level ^ state_reg.pol_inv;
      end else if (set_a) begin
         case (state_reg.pin_func)
            FUNC_LOW: begin
               state_next.pin = 1'b0;
            end
            FUNC_HIGH: begin
               state_next.pin = 1'b1;
            end
            FUNC_TOGGLE: begin
               state_next.pin = !state_reg.pin;
            end
            default: begin
               state_next.pin = state_reg.pin;
            end
         endcase
      end
   end

   // State register; reset loads constants only.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         state_reg <= STATE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // Every output is a flip-flop of the state record.
   assign wb_dat_o     = state_reg.rdata;
   assign wb_ack_o     = state_reg.ack;
   assign pin_out      = state_reg.pin;
   assign pin_oe       = state_reg.pin_en;
   assign match_a_flag = state_reg.flag_a;
   assign match_p_flag = state_reg.flag_p;

endmodule // ctm_timer

`default_nettype wire

// File: rtl/ctm_pkg.sv
package ctm_pkg;

   // Counter geometry.
   localparam int CNT_W    = 10;
   localparam int P_W      = 3;
   localparam int P_SHIFT  = 7;
   localparam logic [10:0] FULL_RANGE = 11'h400;  // 1024 counts.

   // Register byte offsets on the bus.
   localparam logic [7:0] ADDR_CTRL   = 8'h00;
   localparam logic [7:0] ADDR_CONFIG = 8'h04;
   localparam logic [7:0] ADDR_CMP_A  = 8'h08;
   localparam logic [7:0] ADDR_CMP_P  = 8'h0c;
   localparam logic [7:0] ADDR_COUNT  = 8'h10;
   localparam logic [7:0] ADDR_STATUS = 8'h14;

   // Control register fields.
   localparam int CTRL_ON_BIT = 0;

   // Configuration register fields (timer_control_one).
   localparam int CFG_CLR_SEL_BIT = 0;
   localparam int CFG_SWAP_BIT    = 1;
   localparam int CFG_POL_BIT     = 2;
   localparam int CFG_INIT_BIT    = 3;
   localparam int CFG_FUNC_LSB    = 4;
   localparam int CFG_MODE_LSB    = 6;

   // Status register fields; flags are write-one-to-clear.
   localparam int STAT_A_BIT   = 0;
   localparam int STAT_P_BIT   = 1;
   localparam int STAT_PIN_BIT = 2;

   // Reset values.
   localparam logic [7:0]       CONFIG_RESET = 8'h00;
   localparam logic [CNT_W-1:0] CMP_A_RESET  = 10'h000;
   localparam logic [P_W-1:0]   CMP_P_RESET  = 3'h0;

   // Operating modes.
   typedef enum logic [1:0] {
      MODE_COMPARE = 2'h0,
      MODE_SPARE   = 2'h1,
      MODE_PWM     = 2'h2,
      MODE_TIMER   = 2'h3
   } mode_type;

   // Pin function codes, compare output mode.
   localparam logic [1:0] FUNC_HOLD   = 2'h0;
   localparam logic [1:0] FUNC_LOW    = 2'h1;
   localparam logic [1:0] FUNC_HIGH   = 2'h2;
   localparam logic [1:0] FUNC_TOGGLE = 2'h3;

   // Pin function codes, PWM mode.
   localparam logic [1:0] FUNC_FORCE_OFF = 2'h0;
   localparam logic [1:0] FUNC_FORCE_ON  = 2'h1;

endpackage

// File: rtl/ctm_compare.sv
`timescale 1ns/100ps
`default_nettype none

module ctm_compare
   import ctm_pkg::*;
(
   input  wire logic [CNT_W-1:0] count,
   input  wire logic [CNT_W-1:0] cmp_a,
   input  wire logic [P_W-1:0]   cmp_p,
   output logic                  a_hit,
   output logic                  p_hit
);

   logic [CNT_W:0] inc;

   // Matches look at the next count so the clear lands exactly on the match.
   assign inc = {1'b0, count} + 11'h001;

   assign a_hit = (cmp_a != 10'h000) && (inc == {1'b0, cmp_a});

   // upper bits P
   // A zero P value matches the 10-bit overflow, which is its clear point.
   assign p_hit = (inc[P_SHIFT-1:0] == 7'h00) && (inc[CNT_W-1:P_SHIFT] == cmp_p);

endmodule // ctm_compare

`default_nettype wire

// File: rtl/ctm_pwm_level.sv
`timescale 1ns/100ps
`default_nettype none

module ctm_pwm_level
   import ctm_pkg::*;
(
   input  wire logic [CNT_W-1:0] count,
   input  wire logic [CNT_W-1:0] cmp_a,
   input  wire logic [P_W-1:0]   cmp_p,
   input  wire logic             swap,
   output logic                  active
);

   logic [CNT_W:0] p_len;
   logic [CNT_W:0] a_len;
   logic [CNT_W:0] period;
   logic [CNT_W:0] duty;

   assign p_len = (cmp_p == 3'h0) ? FULL_RANGE : {1'b0, cmp_p, 7'h00};
   // A zero A value only clears by overflow, so it spans the whole range.
   assign a_len = (cmp_a == 10'h000) ? FULL_RANGE : {1'b0, cmp_a};

   assign period = swap ? a_len : p_len;
   assign duty   = swap ? p_len : {1'b0, cmp_a};

   assign active = (duty >= period) || ({1'b0, count} < duty);

endmodule // ctm_pwm_level

`default_nettype wire

// File: tb/ctm_checker.sv
`timescale 1ns/100ps
`default_nettype none
module ctm_checker
   import ctm_pkg::*;
(
   input wire logic        clk,
   input wire logic        nrst,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        pin_out,
   input wire logic        pin_oe,
   input wire logic        match_a_flag,
   input wire logic        match_p_flag
);
   logic [7:0] cfg_reg;
   logic [1:0] age_reg;
   logic       wr;
   logic       ok;
   logic       st;
   // A write lands at the edge where ack is high, so decode it the same way.
   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
   assign st = wr && wb_adr_i == ADDR_STATUS;
   assign ok = age_reg == 2'h3;
   // Shadow of the config; outputs lag it, so checks wait three edges.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_reg <= 8'h00;
         age_reg <= 2'h0;
      end else if (wr && wb_adr_i == ADDR_CONFIG) begin
         cfg_reg <= wb_dat_i[7:0];
         age_reg <= 2'h0;
      end else if (!ok) begin
         age_reg <= age_reg + 2'h1;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   property p_ack_pulse;
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
   property p_ack_answer;
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
   endproperty
   a_ack_answer: assert property (p_ack_answer) else $error("ack missing");
   property p_dat_idle;
      !wb_ack_o |-> wb_dat_o == 32'h0;
   endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data not idle");
   property p_oe_mode;
      ok |-> pin_oe == !cfg_reg[CFG_MODE_LSB];
   endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("pin enable wrong");
   property p_a_sticky;
      match_a_flag && !(st && wb_dat_i[STAT_A_BIT]) |=> match_a_flag;
   endproperty
   a_a_sticky: assert property (p_a_sticky) else $error("A flag lost");
   property p_p_sticky;
      match_p_flag && !(st && wb_dat_i[STAT_P_BIT]) |=> match_p_flag;
   endproperty
   a_p_sticky: assert property (p_p_sticky) else $error("P flag lost");
   property p_no_p;
      ok && cfg_reg[CFG_CLR_SEL_BIT] && cfg_reg[7:6] != MODE_PWM && !match_p_flag
         |=> !match_p_flag;
   endproperty
   a_no_p: assert property (p_no_p) else $error("P flag set");
   property p_forced;
      ok && cfg_reg[7:6] == MODE_PWM && !cfg_reg[5] && !cfg_reg[CFG_POL_BIT]
         |-> pin_out == (cfg_reg[CFG_FUNC_LSB] ~^ cfg_reg[CFG_INIT_BIT]);
   endproperty
   a_forced: assert property (p_forced) else $error("forced level wrong");
endmodule // ctm_checker
bind ctm_timer ctm_checker u_ctm_checker (
   .clk(clk), .nrst(nrst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .pin_out(pin_out), .pin_oe(pin_oe), .match_a_flag(match_a_flag),
   .match_p_flag(match_p_flag)
);
`default_nettype wire

// File: tb/ctm_load.sv
`timescale 1ns/100ps
`default_nettype none
module ctm_load (
   input  wire logic        clk,
   input  wire logic        nrst,
   input  wire logic        pin_out,
   input  wire logic        pin_oe,
   input  wire logic        clr,
   output logic      [10:0] high_cnt,
   output logic      [10:0] rise_cnt
);
   logic last;
   // The load only feels the pin while the timer drives it.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         high_cnt <= 11'h000;
         rise_cnt <= 11'h000;
      end else if (clr) begin
         high_cnt <= 11'h000;
         rise_cnt <= 11'h000;
      end else if (pin_oe) begin
         high_cnt <= high_cnt + 11'(pin_out);
         rise_cnt <= rise_cnt + 11'(pin_out && !last);
      end
   end
   // Last level, kept apart so a window clear does not fake a rise.
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         last <= 1'b0;
      end else begin
         last <= pin_out;
      end
   end
endmodule // ctm_load
`default_nettype wire

// File: tb/compact_timer_compare_pwm_bench.sv
`timescale 1ns/100ps
`default_nettype none
module compact_timer_compare_pwm_bench
   import ctm_pkg::*;
;
   logic        clk  = 1'b0;
   logic        nrst = 1'b0;
   logic        cyc  = 1'b0;
   logic        stb  = 1'b0;
   logic        we   = 1'b0;
   logic [7:0]  adr  = 8'h00;
   logic [31:0] dat  = 32'h0;
   logic        clr  = 1'b0;
   logic [31:0] rdat;
   logic        ack;
   logic        pin;
   logic        oe;
   logic        fa;
   logic        fp;
   logic [10:0] hi;
   logic [10:0] rs;
   int          fails = 0;
   int          cmp_count = 0;
   ctm_timer u_ctm_timer (
      .clk(clk), .nrst(nrst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .pin_out(pin), .pin_oe(oe), .match_a_flag(fa),
      .match_p_flag(fp)
   );
   ctm_load u_ctm_load (
      .clk(clk), .nrst(nrst), .pin_out(pin), .pin_oe(oe), .clr(clr),
      .high_cnt(hi), .rise_cnt(rs)
   );
   // Free running 25 MHz clock.
   initial begin
      forever #20 clk = ~clk;
   end
   // Counts and verdict; the single place where the run ends.
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One classic cycle; ack and read data are taken at the rising edge that shows ack.
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int i;
      i = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we  <= w;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
         i++;
      end while (ack !== 1'b1 && i < 20);
      q = rdat;
      if (ack !== 1'b1) begin
         fails++;
         test_done();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q & m, e);
   endtask
   // Clears the load counters, then lets a window of n cycles pass.
   task automatic window(input int n);
      @(posedge clk);
      clr <= 1'b1;
      @(posedge clk);
      clr <= 1'b0;
      repeat (n) @(posedge clk);
      @(negedge clk);
   endtask
   // Config is only touched with the timer stopped.
   task automatic start(input logic [7:0] c, input logic [31:0] a, input logic [31:0] p);
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_CONFIG, {24'h0, c});
      wr(ADDR_CMP_A, a);
      wr(ADDR_CMP_P, p);
      wr(ADDR_STATUS, 32'h3);
      wr(ADDR_CTRL, 32'h1);
   endtask
   task automatic t_reset();
      logic [7:0] ad[6] = '{ADDR_CONFIG, ADDR_CMP_A, ADDR_CMP_P, ADDR_COUNT,
                            ADDR_STATUS, 8'h1c};
      foreach (ad[i]) begin
         rdc(ad[i], 32'hffffffff, 32'h0);
      end
      wr(ADDR_CMP_A, 32'hffff);
      rdc(ADDR_CMP_A, 32'hffffffff, 32'h3ff);
      wr(ADDR_COUNT, 32'h55);
      rdc(ADDR_COUNT, 32'hffffffff, 32'h0);
      $display("reset test done");
   endtask
   task automatic t_clr_a();
      for (int f = 0; f < 4; f++) begin
         start({2'h0, f[1:0], 4'h9}, 32'd300, 32'h1);
         @(negedge clk);
         check(32'(pin), 32'h1);
         window(750);
         check(32'(pin), 32'(f != 1));
         check(32'(rs), 32'(f == 3));
         rdc(ADDR_STATUS, 32'h3, 32'h1);
         rdc(ADDR_COUNT, 32'hffffff00, 32'h0);
      end
      $display("clear on A test done");
   endtask
   task automatic t_clr_p();
      for (int m = 0; m < 4; m += 3) begin
         start({m[1:0], 6'h30}, 32'd50, 32'h2);
         window(512);
         check(32'(oe), 32'(m == 0));
         check(32'(rs), 32'(m == 0));
         rdc(ADDR_STATUS, 32'h3, 32'h3);
         rdc(ADDR_COUNT, 32'hffffff00, 32'h0);
      end
      start(8'hc1, 32'h0, 32'h1);
      window(1100);
      rdc(ADDR_STATUS, 32'h3, 32'h0);
      $display("clear on P test done");
   endtask
   task automatic t_pwm();
      logic [7:0] cf[5] = '{8'ha8, 8'ha9, 8'haa, 8'ha8, 8'hac};
      int         av[5] = '{32, 200, 300, 32, 32};
      int         pv[5] = '{1, 1, 1, 0, 1};
      int         wn[5] = '{128, 128, 300, 1024, 128};
      int         hv[5] = '{32, 128, 128, 32, 96};
      int         fl[5] = '{3, 2, 3, 3, 3};
      foreach (cf[i]) begin
         start(cf[i], 32'(av[i]), 32'(pv[i]));
         repeat (wn[i] + 8) @(posedge clk);
         window(wn[i]);
         check(32'(hi), 32'(hv[i]));
         rdc(ADDR_STATUS, 32'h3, 32'(fl[i]));
      end
      wr(ADDR_CTRL, 32'h0);
      wr(ADDR_CONFIG, 32'h88);
      window(4);
      check(32'(pin), 32'h0);
      wr(ADDR_CONFIG, 32'h98);
      window(4);
      check(32'(pin), 32'h1);
      $display("pwm test done");
   endtask
   // Main sequence.
   initial begin
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_clr_a();
      t_clr_p();
      t_pwm();
      test_done();
   end
endmodule // compact_timer_compare_pwm_bench
`default_nettype wire
